// ==== hdl/srad_params.svh ====
// Constants for the serial register address decoder
`ifndef SRAD_PARAMS_SVH
`define SRAD_PARAMS_SVH

// Frame layout, LSB first on the wire
`define SRAD_FRAME_BITS 16
`define SRAD_ADDR_BITS 8
`define SRAD_ONE_BIT 0
`define SRAD_AUX_BIT 1
`define SRAD_CODE_LSB 2
`define SRAD_CODE_MSB 6
`define SRAD_OP_BIT 7
`define SRAD_DATA_LSB 8
`define SRAD_DATA_MSB 15

// Register counts
`define SRAD_NUM_CTRL 10
`define SRAD_NUM_STAT 5

// Register select codes, address bits 6 down to 2
`define SRAD_CODE_ACT_A 5'h00
`define SRAD_CODE_ACT_B 5'h10
`define SRAD_CODE_MODE_A 5'h18
`define SRAD_CODE_MODE_B 5'h04
`define SRAD_CODE_FREQ 5'h0C
`define SRAD_CODE_DUTY1 5'h1C
`define SRAD_CODE_DUTY2 5'h02
`define SRAD_CODE_DUTY3 5'h12
`define SRAD_CODE_CONFIG 5'h19
`define SRAD_CODE_OVP 5'h03
`define SRAD_CODE_RSVD_A 5'h13
`define SRAD_CODE_OLDN 5'h07
`define SRAD_CODE_RSVD_B 5'h17
`define SRAD_CODE_GSTAT1 5'h06
`define SRAD_CODE_OERR1 5'h16
`define SRAD_CODE_OERR2 5'h0E
`define SRAD_CODE_OERR4 5'h01
`define SRAD_CODE_OERR5 5'h11

// No-match indices for the control and status register banks
`define SRAD_IDX_NONE 4'hF
`define SRAD_SIDX_NONE 3'h7

// Reset values
`define SRAD_CTRL_RESET 8'h00
`define SRAD_STAT_RESET 8'h00

// Serial clock timing at the host end
`define SRAD_CLK_NS 10
`define SRAD_HALF_NS 50
`define SRAD_HALF_CYC ((`SRAD_HALF_NS + `SRAD_CLK_NS - 1) / `SRAD_CLK_NS)

`endif

// ==== hdl/srad_pkg.sv ====
// Types shared by both ends of the serial register link
`include "srad_params.svh"

package srad_pkg;

  typedef logic [7:0] srad_byte_t;
  typedef logic [4:0] srad_code_t;
  typedef srad_byte_t [`SRAD_NUM_CTRL-1:0] srad_ctrl_bank_t;
  typedef srad_byte_t [`SRAD_NUM_STAT-1:0] srad_stat_bank_t;
  typedef logic [`SRAD_FRAME_BITS-1:0] srad_frame_t;

  typedef enum logic [2:0] {
    SRAD_H_IDLE,
    SRAD_H_LEAD,
    SRAD_H_HIGH,
    SRAD_H_LOW,
    SRAD_H_TRAIL,
    SRAD_H_GAP
  } srad_host_state_t;

endpackage

// ==== hdl/srad_if.sv ====
// Serial link between bus master and register decoder
`timescale 1ns/1ps

interface srad_if;
  logic sclk;
  logic chip_sel_n;
  logic mosi;
  logic miso;

  modport device (
    input sclk,
    input chip_sel_n,
    input mosi,
    output miso
  );

  modport host (
    output sclk,
    output chip_sel_n,
    output mosi,
    input miso
  );
endinterface

// ==== hdl/srad_shift.sv ====
// LSB-first serial-in shift register
`timescale 1ns/1ps
`include "srad_params.svh"

module srad_shift #(
  parameter int WIDTH = `SRAD_FRAME_BITS
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic shift_en,
  input wire logic bit_in,
  output logic [WIDTH-1:0] data
);

  // First bit received ends in bit 0 after WIDTH shifts
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      data <= '0;
    end else if (clear) begin
      data <= '0;
    end else if (shift_en) begin
      data <= {bit_in, data[WIDTH-1:1]};
    end
  end

endmodule

// ==== hdl/srad_device_end.sv ====
// Device end: frame decode, control and status register bank
`timescale 1ns/1ps
`include "srad_params.svh"

module srad_device_end (
  input wire logic ref_clk,
  input wire logic reset,
  srad_if.device link,
  input wire srad_pkg::srad_byte_t config_value,
  input wire srad_pkg::srad_stat_bank_t fault_set,
  output srad_pkg::srad_ctrl_bank_t ctrl_regs,
  output srad_pkg::srad_stat_bank_t stat_regs,
  output logic aux_flag,
  output logic write_done,
  output logic frame_error
);
  import srad_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [3:0] ctrl_index(input srad_code_t code);
    case (code)
      `SRAD_CODE_ACT_A: ctrl_index = 4'h0;
      `SRAD_CODE_ACT_B: ctrl_index = 4'h1;
      `SRAD_CODE_MODE_A: ctrl_index = 4'h2;
      `SRAD_CODE_MODE_B: ctrl_index = 4'h3;
      `SRAD_CODE_FREQ: ctrl_index = 4'h4;
      `SRAD_CODE_DUTY1: ctrl_index = 4'h5;
      `SRAD_CODE_DUTY2: ctrl_index = 4'h6;
      `SRAD_CODE_DUTY3: ctrl_index = 4'h7;
      `SRAD_CODE_OVP: ctrl_index = 4'h8;
      `SRAD_CODE_OLDN: ctrl_index = 4'h9;
      default: ctrl_index = `SRAD_IDX_NONE;
    endcase
  endfunction

  function automatic logic [2:0] stat_index(input srad_code_t code);
    case (code)
      `SRAD_CODE_GSTAT1: stat_index = 3'h0;
      `SRAD_CODE_OERR1: stat_index = 3'h1;
      `SRAD_CODE_OERR2: stat_index = 3'h2;
      `SRAD_CODE_OERR4: stat_index = 3'h3;
      `SRAD_CODE_OERR5: stat_index = 3'h4;
      default: stat_index = `SRAD_SIDX_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link edge detection

  logic sclk_prev_reg;
  logic csn_prev_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic csn_fall;
  logic csn_rise;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclk_prev_reg <= 1'b0;
      csn_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= link.sclk;
      csn_prev_reg <= link.chip_sel_n;
    end
  end

  assign sclk_rise = link.sclk & ~sclk_prev_reg & ~link.chip_sel_n;
  assign sclk_fall = ~link.sclk & sclk_prev_reg & ~link.chip_sel_n;
  assign csn_fall = ~link.chip_sel_n & csn_prev_reg;
  assign csn_rise = link.chip_sel_n & ~csn_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bit counter and receive shifter

  logic [4:0] bit_cnt_reg;
  srad_frame_t rx_data;
  logic shift_en;

  assign shift_en = sclk_rise && (bit_cnt_reg < 5'(`SRAD_FRAME_BITS));

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bit_cnt_reg <= 5'h00;
    end else if (csn_fall) begin
      bit_cnt_reg <= 5'h00;
    end else if (shift_en) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  srad_shift #(
    .WIDTH(`SRAD_FRAME_BITS)
  ) u_rx (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(csn_fall),
    .shift_en(shift_en),
    .bit_in(link.mosi),
    .data(rx_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode

  srad_byte_t addr_byte;
  srad_byte_t data_byte;
  srad_code_t code;
  logic op_high;
  logic frame_done;
  logic [3:0] wr_idx;
  logic [2:0] st_idx;

  // Address byte arrives first, data byte second
  assign addr_byte = rx_data[`SRAD_ADDR_BITS-1:0];
  assign data_byte = rx_data[`SRAD_DATA_MSB:`SRAD_DATA_LSB];
  assign code = addr_byte[`SRAD_CODE_MSB:`SRAD_CODE_LSB];
  assign op_high = addr_byte[`SRAD_OP_BIT];
  assign wr_idx = ctrl_index(code);
  assign st_idx = stat_index(code);

  // Full frame with marker bit set
  assign frame_done = csn_rise
    && (bit_cnt_reg == 5'(`SRAD_FRAME_BITS))
    && addr_byte[`SRAD_ONE_BIT];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      aux_flag <= 1'b0;
      frame_error <= 1'b0;
    end else begin
      // Ignored writes leave the flag alone too
      if (frame_done && !(op_high && (wr_idx == `SRAD_IDX_NONE)
          && (st_idx == `SRAD_SIDX_NONE))) begin
        aux_flag <= addr_byte[`SRAD_AUX_BIT];
      end
      frame_error <= csn_rise && !frame_done && (bit_cnt_reg != 5'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_regs <= {`SRAD_NUM_CTRL{`SRAD_CTRL_RESET}};
      write_done <= 1'b0;
    end else begin
      // Config and reserved codes map to no index
      write_done <= frame_done && op_high && (wr_idx != `SRAD_IDX_NONE);
      for (int i = 0; i < `SRAD_NUM_CTRL; i++) begin
        if (frame_done && op_high && (wr_idx == 4'(i))) begin
          ctrl_regs[i] <= data_byte;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status registers, sticky with guarded clear

  logic [`SRAD_NUM_STAT-1:0] late_fault_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      late_fault_reg <= '0;
    end else if (csn_fall) begin
      late_fault_reg <= '0;
    end else if (!link.chip_sel_n && (bit_cnt_reg >= 5'h08)) begin
      for (int k = 0; k < `SRAD_NUM_STAT; k++) begin
        late_fault_reg[k] <= late_fault_reg[k] | (|fault_set[k]);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stat_regs <= {`SRAD_NUM_STAT{`SRAD_STAT_RESET}};
    end else begin
      for (int k = 0; k < `SRAD_NUM_STAT; k++) begin
        // New event wins over a clear in the same cycle
        if (frame_done && op_high && (st_idx == 3'(k))
            && !late_fault_reg[k]) begin
          stat_regs[k] <= fault_set[k];
        end else begin
          stat_regs[k] <= stat_regs[k] | fault_set[k];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection

  srad_byte_t rd_byte;
  srad_byte_t cur_addr;
  srad_code_t cur_code;
  logic [3:0] rd_cidx;
  logic [2:0] rd_sidx;

  // At bit eight the address sits in the upper half of the shifter
  assign cur_addr = rx_data[`SRAD_DATA_MSB:`SRAD_DATA_LSB];
  assign cur_code = cur_addr[`SRAD_CODE_MSB:`SRAD_CODE_LSB];
  assign rd_cidx = ctrl_index(cur_code);
  assign rd_sidx = stat_index(cur_code);

  always_comb begin
    rd_byte = 8'h00;
    if (cur_code == `SRAD_CODE_CONFIG) begin
      rd_byte = config_value;
    end else if (rd_cidx != `SRAD_IDX_NONE) begin
      rd_byte = ctrl_regs[rd_cidx];
    end else if (rd_sidx != `SRAD_SIDX_NONE) begin
      rd_byte = stat_regs[rd_sidx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response shifting, global status then data byte

  srad_byte_t gstat_hold_reg;
  srad_byte_t data_hold_reg;
  logic miso_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gstat_hold_reg <= 8'h00;
      data_hold_reg <= 8'h00;
      miso_reg <= 1'b0;
    end else if (csn_fall) begin
      gstat_hold_reg <= stat_regs[0];
      miso_reg <= stat_regs[0][0];
    end else if (link.chip_sel_n) begin
      miso_reg <= 1'b0;
    end else if (sclk_fall) begin
      if (bit_cnt_reg < 5'h08) begin
        miso_reg <= gstat_hold_reg[bit_cnt_reg[2:0]];
      end else if (bit_cnt_reg == 5'h08) begin
        data_hold_reg <= rd_byte;
        miso_reg <= rd_byte[0];
      end else if (bit_cnt_reg < 5'(`SRAD_FRAME_BITS)) begin
        miso_reg <= data_hold_reg[bit_cnt_reg[2:0]];
      end
    end
  end

  assign link.miso = miso_reg;

endmodule

// ==== hdl/srad_host_end.sv ====
// Host end: serial bus master issuing one frame per request
`timescale 1ns/1ps
`include "srad_params.svh"

module srad_host_end #(
  parameter int HALF_CYC = `SRAD_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  srad_if.host link,
  input wire logic req_valid,
  input wire srad_pkg::srad_code_t req_code,
  input wire logic req_write,
  input wire logic req_aux,
  input wire srad_pkg::srad_byte_t req_data,
  output logic busy,
  output logic resp_valid,
  output srad_pkg::srad_byte_t resp_status,
  output srad_pkg::srad_byte_t resp_data
);
  import srad_pkg::*;

  srad_host_state_t state_reg;
  logic [15:0] wait_reg;
  logic [3:0] bit_reg;
  srad_frame_t tx_reg;
  srad_frame_t rx_data;
  logic sclk_reg;
  logic csn_n_reg;
  logic mosi_reg;
  logic wait_done;
  logic sample;

  assign wait_done = (wait_reg == 16'(HALF_CYC - 1));
  assign sample = wait_done
    && ((state_reg == SRAD_H_LEAD) || (state_reg == SRAD_H_LOW));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= SRAD_H_IDLE;
      wait_reg <= 16'h0000;
      bit_reg <= 4'h0;
      tx_reg <= '0;
    end else begin
      wait_reg <= wait_done ? 16'h0000 : wait_reg + 16'h0001;
      case (state_reg)
        SRAD_H_IDLE: begin
          wait_reg <= 16'h0000;
          bit_reg <= 4'h0;
          if (req_valid) begin
            // Bit 0 fixed one, op in bit 7, data in upper byte
            tx_reg <= {req_data, req_write, req_code, req_aux, 1'b1};
            state_reg <= SRAD_H_LEAD;
          end
        end
        SRAD_H_LEAD: if (wait_done) state_reg <= SRAD_H_HIGH;
        SRAD_H_HIGH: begin
          if (wait_done) begin
            bit_reg <= bit_reg + 4'h1;
            state_reg <= (bit_reg == 4'hF) ? SRAD_H_TRAIL : SRAD_H_LOW;
          end
        end
        SRAD_H_LOW: if (wait_done) state_reg <= SRAD_H_HIGH;
        SRAD_H_TRAIL: if (wait_done) state_reg <= SRAD_H_GAP;
        SRAD_H_GAP: if (wait_done) state_reg <= SRAD_H_IDLE;
        default: state_reg <= SRAD_H_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclk_reg <= 1'b0;
      csn_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
    end else begin
      case (state_reg)
        SRAD_H_IDLE: begin
          if (req_valid) begin
            csn_n_reg <= 1'b0;
            mosi_reg <= 1'b1;
          end
        end
        SRAD_H_LEAD, SRAD_H_LOW: if (wait_done) sclk_reg <= 1'b1;
        SRAD_H_HIGH: begin
          if (wait_done) begin
            sclk_reg <= 1'b0;
            if (bit_reg != 4'hF) begin
              mosi_reg <= tx_reg[bit_reg + 4'h1];
            end
          end
        end
        SRAD_H_TRAIL: if (wait_done) csn_n_reg <= 1'b1;
        default: begin
        end
      endcase
    end
  end

  assign link.sclk = sclk_reg;
  assign link.chip_sel_n = csn_n_reg;
  assign link.mosi = mosi_reg;

  srad_shift #(
    .WIDTH(`SRAD_FRAME_BITS)
  ) u_rx (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(state_reg == SRAD_H_IDLE),
    .shift_en(sample),
    .bit_in(link.miso),
    .data(rx_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // User answer

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      resp_valid <= 1'b0;
      resp_status <= 8'h00;
      resp_data <= 8'h00;
    end else begin
      resp_valid <= 1'b0;
      if (state_reg == SRAD_H_IDLE && req_valid) begin
        busy <= 1'b1;
      end else if (state_reg == SRAD_H_GAP && wait_done) begin
        busy <= 1'b0;
      end
      if (state_reg == SRAD_H_TRAIL && wait_done) begin
        resp_valid <= 1'b1;
        resp_status <= rx_data[`SRAD_ADDR_BITS-1:0];
        resp_data <= rx_data[`SRAD_DATA_MSB:`SRAD_DATA_LSB];
      end
    end
  end

endmodule

// ==== sim/srad_link_properties.sv ====
// Wire-level checks on the serial link between the two ends
`timescale 1ns/1ps

module srad_link_properties (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic chip_sel_n,
  input wire logic mosi,
  input wire logic miso
);
  logic sclk_d_reg;
  logic [4:0] edge_cnt_reg;

  default clocking
    @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) sclk_d_reg <= 1'b0;
    else sclk_d_reg <= sclk;
  end

  // Rising serial clock edges inside a frame
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) edge_cnt_reg <= 5'h00;
    else if (chip_sel_n) edge_cnt_reg <= 5'h00;
    else if (sclk && !sclk_d_reg) edge_cnt_reg <= edge_cnt_reg + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  a_idle_clock_low: assert property (chip_sel_n |-> !sclk)
    else $error("serial clock active outside a frame");
  a_sixteen_bits: assert property ($rose(chip_sel_n) |->
    edge_cnt_reg == 5'h10) else $error("frame without sixteen bits");
  a_first_bit_one: assert property ($fell(chip_sel_n) |-> mosi)
    else $error("address bit zero not one");
  a_lead_time: assert property ($fell(chip_sel_n) |-> !sclk [*3])
    else $error("serial clock too early in frame");
  a_frame_length: assert property ($fell(chip_sel_n) |->
    ##[96:102] $rose(chip_sel_n)) else $error("frame length off");
  a_mosi_held: assert property (sclk && $past(sclk) |->
    $stable(mosi)) else $error("host data moved while clock high");
  a_miso_held: assert property (sclk && $past(sclk) |->
    $stable(miso)) else $error("device data moved while clock high");
  a_gap_kept: assert property ($rose(chip_sel_n) |-> chip_sel_n [*3])
    else $error("frame gap too short");
endmodule

// ==== sim/spi_register_address_decoder_test.sv ====
// Self-checking bench joining host end and device end
`timescale 1ns/1ps

module spi_register_address_decoder_test;
  import srad_pkg::*;

  logic ref_clk;
  logic reset;
  logic req_valid;
  srad_code_t req_code;
  logic req_write;
  logic req_aux;
  srad_byte_t req_data;
  logic busy;
  logic resp_valid;
  srad_byte_t resp_status;
  srad_byte_t resp_data;
  srad_byte_t config_value;
  srad_stat_bank_t fault_set;
  srad_ctrl_bank_t ctrl_regs;
  srad_stat_bank_t stat_regs;
  logic aux_flag;
  logic write_done;
  logic frame_error;
  int errors;
  int check_count;
  int seed;
  int wd_count;
  srad_byte_t v;
  srad_byte_t exp_q[$];
  srad_byte_t st_q[$];
  srad_byte_t gstat_exp;
  srad_byte_t shadow[10];
  srad_code_t ctrl_code[10] = '{5'h00, 5'h10, 5'h18, 5'h04, 5'h0C, 5'h1C,
    5'h02, 5'h12, 5'h03, 5'h07};
  srad_code_t stat_code[5] = '{5'h06, 5'h16, 5'h0E, 5'h01, 5'h11};

  srad_if link_if ();
  srad_host_end #(.HALF_CYC(3)) srad_host_end_inst (
    .ref_clk(ref_clk), .reset(reset), .link(link_if.host),
    .req_valid(req_valid), .req_code(req_code), .req_write(req_write),
    .req_aux(req_aux), .req_data(req_data), .busy(busy),
    .resp_valid(resp_valid), .resp_status(resp_status),
    .resp_data(resp_data));
  srad_device_end srad_device_end_inst (
    .ref_clk(ref_clk), .reset(reset), .link(link_if.device),
    .config_value(config_value), .fault_set(fault_set),
    .ctrl_regs(ctrl_regs), .stat_regs(stat_regs), .aux_flag(aux_flag),
    .write_done(write_done), .frame_error(frame_error));
  srad_link_properties srad_link_properties_inst (
    .ref_clk(ref_clk), .reset(reset), .sclk(link_if.sclk),
    .chip_sel_n(link_if.chip_sel_n), .mosi(link_if.mosi),
    .miso(link_if.miso));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One request; exp is the data byte the frame must return
  task automatic frame(input srad_code_t code, input logic wr,
      input logic aux, input srad_byte_t data, input srad_byte_t exp);
    int n;
    exp_q.push_back(exp);
    st_q.push_back(gstat_exp);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_code <= code;
    req_write <= wr;
    req_aux <= aux;
    req_data <= data;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 400);
    if (n >= 400) begin
      errors++;
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (write_done === 1'b1) wd_count++;
    if (frame_error !== 1'b0 && !reset) check(frame_error, 1'b0);
    if (resp_valid === 1'b1) begin
      if (exp_q.size() == 0) errors++;
      else begin
        check(resp_data, exp_q.pop_front());
        check(resp_status, st_q.pop_front());
      end
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    seed = 4652;
    errors = 0;
    check_count = 0;
    wd_count = 0;
    gstat_exp = 8'h00;
    reset = 1'b1;
    req_valid = 1'b0;
    req_code = 5'h00;
    req_write = 1'b0;
    req_aux = 1'b0;
    req_data = 8'h00;
    config_value = 8'h00;
    fault_set = '0;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    config_value <= 8'($random(seed));
    // Write every control register, then read each back
    for (int i = 0; i < 10; i++) begin
      shadow[i] = 8'($random(seed));
      frame(ctrl_code[i], 1'b1, i[0], shadow[i], 8'h00);
      check(ctrl_regs[i], shadow[i]);
      check(aux_flag, i[0]);
    end
    for (int i = 0; i < 10; i++) begin
      frame(ctrl_code[i], 1'b0, 1'b0, 8'($random(seed)), shadow[i]);
    end
    check(8'(wd_count), 8'h0A);
    // Read-only and reserved codes take no write
    frame(5'h19, 1'b1, 1'b0, 8'($random(seed)), config_value);
    frame(5'h13, 1'b1, 1'b0, 8'($random(seed)), 8'h00);
    frame(5'h17, 1'b1, 1'b1, 8'($random(seed)), 8'h00);
    check(aux_flag, 1'b0);
    frame(5'h19, 1'b0, 1'b0, 8'h00, config_value);
    check(8'(wd_count), 8'h0A);
    // Raise, read, then clear each status register
    for (int j = 0; j < 5; j++) begin
      v = 8'($random(seed)) | 8'h01;
      @(posedge ref_clk);
      fault_set[j] <= v;
      @(posedge ref_clk);
      fault_set[j] <= 8'h00;
      repeat (2) @(posedge ref_clk);
      #1;
      check(stat_regs[j], v);
      gstat_exp = (j == 0) ? v : 8'h00;
      frame(stat_code[j], 1'b0, 1'b0, 8'($random(seed)), v);
      check(stat_regs[j], v);
      frame(stat_code[j], 1'b1, 1'b0, 8'($random(seed)), v);
      check(stat_regs[j], 8'h00);
      gstat_exp = 8'h00;
    end
    // Fault during the data byte cancels the clear
    fork
      frame(stat_code[1], 1'b1, 1'b0, 8'h00, 8'h00);
      begin
        // Just after the twelfth serial clock, inside the data byte
        repeat (72) @(posedge ref_clk);
        fault_set[1] <= 8'h04;
        @(posedge ref_clk);
        fault_set[1] <= 8'h00;
      end
    join
    check(stat_regs[1], 8'h04);
    for (int i = 0; i < 10; i++) check(ctrl_regs[i], shadow[i]);
    check(8'(exp_q.size()), 8'h00);
    print_verdict();
  end
endmodule
